/* File: scict_pkg.sv */
package scict_pkg;
    localparam logic [15:0] SCICT_SERIAL_CONTROL_ADDR = 16'hFF7A;
    localparam logic [15:0] SCICT_TRANSMIT_DATA_ADDR  = 16'hFF7B;
    localparam logic [15:0] SCICT_MODE_ADDR           = 16'hFF80;
    localparam logic [15:0] SCICT_IRQ_STATUS_ADDR     = 16'hFF84;
    localparam logic [15:0] SCICT_IRQ_MASK_ADDR       = 16'hFF88;
    localparam logic [15:0] SCICT_RX_DATA_ADDR        = 16'hFF8C;
    localparam logic [7:0]  SCICT_SERIAL_CONTROL_RST  = 8'h00;
    localparam logic [7:0]  SCICT_TRANSMIT_DATA_RST   = 8'hFF;
    localparam logic [7:0]  SCICT_MODE_RST            = 8'h00;
    localparam logic [3:0]  SCICT_IRQ_MASK_RST        = 4'h0;
    localparam int SCICT_BIT_TX_EMPTY_IE = 7;
    localparam int SCICT_BIT_RX_FULL_IE  = 6;
    localparam int SCICT_BIT_TX_ON       = 5;
    localparam int SCICT_BIT_RX_ON       = 4;
    localparam int SCICT_BIT_MP_FILTER   = 3;
    localparam int SCICT_BIT_TX_END_IE   = 2;
    localparam int SCICT_BIT_CLK_EN_HI   = 1;
    localparam int SCICT_BIT_CLK_EN_LO   = 0;
    localparam int SCICT_MODE_BIT_SYNC   = 7;
    localparam int SCICT_MODE_BIT_CHR7   = 6;
    localparam int SCICT_MODE_BIT_MP     = 2;
    localparam int SCICT_MODE_BIT_SMART  = 0;
    localparam int SCICT_IRQ_TX_EMPTY = 0;
    localparam int SCICT_IRQ_TX_END   = 1;
    localparam int SCICT_IRQ_RX_FULL  = 2;
    localparam int SCICT_IRQ_RX_ERR   = 3;
    localparam int SCICT_CLK_HZ       = 50_000_000;
    localparam int SCICT_BIT_RATE_DIV = 16;
    typedef struct packed {
        logic sck_out;
        logic sck_oe_n;
    } scict_pin_t;
    typedef struct packed {
        logic tx_empty_ie;
        logic rx_full_ie;
        logic tx_on;
        logic rx_on;
        logic mp_filter;
        logic tx_end_ie;
        logic clk_en_hi;
        logic clk_en_lo;
    } scict_ctrl_t;
    typedef enum logic [2:0] {
        SCICT_IDLE = 3'b001,
        SCICT_SEND = 3'b010,
        SCICT_RECV = 3'b100
    } scict_state_t;
endpackage

/* File: scict_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module scict_sync (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic d_in,
    output var  logic q_out
);
    logic meta_r;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            meta_r <= 1'b1;
            q_out  <= 1'b1;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule // scict_sync
`default_nettype wire

/* File: scict_top.sv */
`timescale 1ns/1ps
`default_nettype none
module scict_top
    import scict_pkg::*;
#(
    parameter int DIV = SCICT_BIT_RATE_DIV
) (
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [15:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output var  logic [31:0] prdata_out,
    output var  logic        pready_out,
    output var  logic        pslverr_out,
    input  wire logic        rxd_in,
    input  wire logic        sck_in,
    output var  logic        txd_out,
    output var  scict_pin_t  sck_pin_out,
    output var  logic        irq_out
);
    import scict_pkg::*;

    scict_ctrl_t  ctrl_r;
    logic [7:0]   tdata_r;
    logic [7:0]   mode_r;
    logic [3:0]   stat_r;
    logic [3:0]   mask_r;
    logic [7:0]   rdata_r;
    logic         tdata_full_r;
    scict_state_t state_r;
    logic [15:0]  div_r;
    logic         tick;
    logic [3:0]   bit_r;
    logic [10:0]  shift_r;
    logic         sck_int_r;
    logic         rxd_s;
    logic         sck_s;
    logic         sck_d_r;
    logic [3:0]   nbits;
    logic [3:0]   rx_len;
    logic [10:0]  rx_word;
    logic [3:0]   ev;

    // two flops on pins before any logic looks at them
    scict_sync u_rx (.clk_in(clk_in), .reset_in(reset_in), .d_in(rxd_in), .q_out(rxd_s));
    scict_sync u_ck (.clk_in(clk_in), .reset_in(reset_in), .d_in(sck_in), .q_out(sck_s));

    wire acc    = psel_in && penable_in;
    wire wr     = acc && pwrite_in;
    wire rd     = acc && !pwrite_in;
    wire smart  = mode_r[SCICT_MODE_BIT_SMART];
    wire sync_m = mode_r[SCICT_MODE_BIT_SYNC];
    wire chr7   = mode_r[SCICT_MODE_BIT_CHR7] && !sync_m;
    wire mp_on  = mode_r[SCICT_MODE_BIT_MP] && !sync_m;
    wire ext_ck = sync_m && !smart && ctrl_r.clk_en_hi;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= psel_in && !penable_in;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            if (psel_in && !penable_in) begin
                case (paddr_in)
                    SCICT_SERIAL_CONTROL_ADDR: prdata_out <= {24'h000000, ctrl_r};
                    SCICT_TRANSMIT_DATA_ADDR:  prdata_out <= {24'h000000, tdata_r};
                    SCICT_MODE_ADDR:           prdata_out <= {24'h000000, mode_r};
                    SCICT_IRQ_STATUS_ADDR:     prdata_out <= {28'h0000000, stat_r};
                    SCICT_IRQ_MASK_ADDR:       prdata_out <= {28'h0000000, mask_r};
                    SCICT_RX_DATA_ADDR:        prdata_out <= {24'h000000, rdata_r};
                    default:                   pslverr_out <= 1'b1;
                endcase
            end
        end
    end

    // bit-rate divider: one-cycle enable; also the internal serial clock
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            div_r     <= 16'h0000;
            sck_int_r <= 1'b1;
        end else if (div_r == 16'(DIV - 1)) begin
            div_r     <= 16'h0000;
            sck_int_r <= ~sck_int_r;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sck_d_r <= 1'b1;
        end else begin
            sck_d_r <= sck_s;
        end
    end
    wire int_tick = (div_r == 16'(DIV - 1)) && sck_int_r;
    assign tick = ext_ck ? (sck_s && !sck_d_r) : int_tick;
    assign nbits = chr7 ? 4'h7 : 4'h8;
    // samples before the stop bit, start counted; first data bit sits at 12 - rx_len
    assign rx_len  = nbits + (mp_on ? 4'h2 : 4'h1);
    assign rx_word = shift_r >> (4'hC - rx_len);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ctrl_r  <= scict_ctrl_t'(SCICT_SERIAL_CONTROL_RST);
            tdata_r <= SCICT_TRANSMIT_DATA_RST;
            mode_r  <= SCICT_MODE_RST;
            mask_r  <= SCICT_IRQ_MASK_RST;
        end else begin
            if (wr && paddr_in == SCICT_SERIAL_CONTROL_ADDR) begin
                ctrl_r <= scict_ctrl_t'(pwdata_in[7:0]);
            end else if (state_r == SCICT_RECV && tick && bit_r == 4'h0 && mp_on
                         && shift_r[10] && ctrl_r.mp_filter) begin
                ctrl_r.mp_filter <= 1'b0;
            end
            if (wr && paddr_in == SCICT_TRANSMIT_DATA_ADDR) begin
                tdata_r <= pwdata_in[7:0];
            end
            if (wr && paddr_in == SCICT_MODE_ADDR) begin
                mode_r <= pwdata_in[7:0];
            end
            if (wr && paddr_in == SCICT_IRQ_MASK_ADDR) begin
                mask_r <= pwdata_in[3:0];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tdata_full_r <= 1'b0;
        end else if (wr && paddr_in == SCICT_TRANSMIT_DATA_ADDR) begin
            tdata_full_r <= 1'b1;
        end else if (state_r == SCICT_IDLE && tdata_full_r && ctrl_r.tx_on && tick) begin
            tdata_full_r <= 1'b0;
        end
    end

    // single shifter: transmit has priority; half-duplex is a known limitation
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_r <= SCICT_IDLE;
            bit_r   <= 4'h0;
            shift_r <= 11'h7FF;
            txd_out <= 1'b1;
            rdata_r <= 8'h00;
            ev      <= 4'h0;
        end else begin
            ev <= 4'h0;
            case (state_r)
                SCICT_IDLE: begin
                    txd_out <= 1'b1;
                    if (tdata_full_r && ctrl_r.tx_on && tick) begin
                        // chr7 drops bit 7 by shifting only seven data bits
                        shift_r  <= chr7 ? {1'b1, mp_on, 1'b1, tdata_r[6:0], 1'b0}
                                         : {2'b11, tdata_r, 1'b0};
                        bit_r    <= nbits + (mp_on ? 4'h3 : 4'h2);
                        state_r  <= SCICT_SEND;
                        ev[SCICT_IRQ_TX_EMPTY] <= 1'b1;
                    end else if (ctrl_r.rx_on && tick && !rxd_s) begin
                        // start taken on a tick so each later tick lands in its own bit
                        bit_r   <= nbits + (mp_on ? 4'h1 : 4'h0);
                        shift_r <= 11'h000;
                        state_r <= SCICT_RECV;
                    end
                end
                SCICT_SEND: begin
                    if (tick) begin
                        txd_out <= shift_r[0];
                        shift_r <= {1'b1, shift_r[10:1]};
                        bit_r   <= bit_r - 4'h1;
                        if (bit_r == 4'h1) begin
                            state_r  <= SCICT_IDLE;
                            ev[SCICT_IRQ_TX_END] <= 1'b1;
                        end
                    end
                end
                SCICT_RECV: begin
                    if (tick) begin
                        shift_r <= {rxd_s, shift_r[10:1]};
                        bit_r   <= bit_r - 4'h1;
                        if (bit_r == 4'h0) begin
                            state_r <= SCICT_IDLE;
                            if (!ctrl_r.mp_filter || (mp_on && shift_r[10])) begin
                                rdata_r <= chr7 ? {1'b0, rx_word[6:0]} : rx_word[7:0];
                                ev[SCICT_IRQ_RX_FULL] <= 1'b1;
                                ev[SCICT_IRQ_RX_ERR]  <= !rxd_s;
                            end
                        end
                    end
                end
                default: state_r <= SCICT_IDLE;
            endcase
        end
    end

    // sticky status; an event in the clearing read cycle wins
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            stat_r <= 4'h0;
        end else if (rd && paddr_in == SCICT_IRQ_STATUS_ADDR) begin
            stat_r <= ev;
        end else begin
            stat_r <= stat_r | ev;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(stat_r & mask_r & {ctrl_r.rx_full_ie, ctrl_r.rx_full_ie,
                        ctrl_r.tx_end_ie, ctrl_r.tx_empty_ie});
        end
    end

    // clock pin: output enable is active low
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sck_pin_out <= '{sck_out: 1'b1, sck_oe_n: 1'b1};
        end else if (smart) begin
            if (ctrl_r.clk_en_lo) begin
                sck_pin_out <= '{sck_out: sck_int_r, sck_oe_n: 1'b0};
            end else if (!sync_m) begin
                sck_pin_out <= '{sck_out: 1'b1, sck_oe_n: 1'b1};
            end else if (ctrl_r.clk_en_hi) begin
                sck_pin_out <= '{sck_out: 1'b1, sck_oe_n: 1'b0};
            end else begin
                sck_pin_out <= '{sck_out: 1'b0, sck_oe_n: 1'b0};
            end
        end else if (sync_m && !ctrl_r.clk_en_hi) begin
            sck_pin_out <= '{sck_out: sck_int_r, sck_oe_n: 1'b0};
        end else begin
            sck_pin_out <= '{sck_out: 1'b1, sck_oe_n: 1'b1};
        end
    end
endmodule // scict_top
`default_nettype wire

/* File: scict_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module scict_top_properties
    import scict_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        reset_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [15:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        txd_out,
    input wire scict_pin_t  sck_pin_out,
    input wire logic        irq_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    logic mapped;
    assign mapped = paddr_in inside {SCICT_SERIAL_CONTROL_ADDR, SCICT_TRANSMIT_DATA_ADDR,
        SCICT_MODE_ADDR, SCICT_IRQ_STATUS_ADDR, SCICT_IRQ_MASK_ADDR, SCICT_RX_DATA_ADDR};
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_one_ready;
        pready_out ##1 !pready_out;
    endsequence
    a_zero_wait: assert property (s_setup |=> s_one_ready)
        else $error("no single ready after setup");
    a_ready_access: assert property (pready_out |-> psel_in && penable_in)
        else $error("ready outside access phase");
    a_err_with_ready: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    a_unmapped_err: assert property (pready_out && !mapped |-> pslverr_out)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready_out && mapped |-> !pslverr_out)
        else $error("mapped access refused");
    a_refused_zero: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
        else $error("refused read not zero");
    a_upper_zero: assert property (pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_reset_idle: assert property ($past(reset_in) |-> txd_out && !irq_out && sck_pin_out.sck_oe_n)
        else $error("outputs not idle after reset");
endmodule // scict_top_properties
bind scict_top scict_top_properties u_props (.clk_in(clk_in), .reset_in(reset_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .txd_out(txd_out), .sck_pin_out(sck_pin_out), .irq_out(irq_out));
`default_nettype wire

/* File: scict_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module scict_peer #(
    parameter int BIT = 4
) (
    input  wire logic clk_in,
    input  wire logic txd_in,
    output var  logic rxd_out,
    output var  logic sck_out
);
    logic run = 1'b0;
    initial rxd_out = 1'b1;
    initial sck_out = 1'b0;
    // link clock only runs inside a frame
    always #80 sck_out = run ? ~sck_out : 1'b0;
    task automatic send(input logic [7:0] b, input logic mp_on, input logic multiproc_bit);
        logic [10:0] f;
        f = mp_on ? {1'b1, multiproc_bit, b, 1'b0} : {2'b11, b, 1'b0};
        run = 1'b1;
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_in);
            rxd_out <= f[i];
            repeat (BIT - 1) @(posedge clk_in);
        end
        run = 1'b0;
        repeat (4 * BIT) @(posedge clk_in);
    endtask
    // samples mid-bit, eight cells after the start bit
    task automatic get(output logic [7:0] b);
        @(negedge txd_in);
        repeat (BIT / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_in);
            b[i] = txd_in;
        end
    endtask
endmodule // scict_peer
`default_nettype wire

/* File: scict_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module scict_top_bench;
    import scict_pkg::*;
    localparam int DIV   = 2;
    localparam int LIMIT = 20000;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd;
    logic        sck;
    logic        txd;
    scict_pin_t  pin;
    logic        irq;
    int          errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    always #10 clk_in = ~clk_in;
    scict_top #(.DIV(DIV)) uut (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .rxd_in(rxd),
        .sck_in(sck), .txd_out(txd), .sck_pin_out(pin), .irq_out(irq));
    scict_peer #(.BIT(2 * DIV)) u_peer (.clk_in(clk_in), .txd_in(txd), .rxd_out(rxd),
        .sck_out(sck));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d checks %0d", errors, num_checks);
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk_in);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        apb(0, SCICT_SERIAL_CONTROL_ADDR, 0, r, e); chk(r, {24'h0, SCICT_SERIAL_CONTROL_RST});
        apb(0, SCICT_TRANSMIT_DATA_ADDR, 0, r, e); chk(r, {24'h0, SCICT_TRANSMIT_DATA_RST});
        apb(1, SCICT_TRANSMIT_DATA_ADDR, 32'h5A, r, e);
        apb(0, SCICT_TRANSMIT_DATA_ADDR, 0, r, e); chk(r, 32'h5A);
        apb(0, 16'hFF7C, 0, r, e); chk({e, r[30:0]}, 32'h8000_0000);
    endtask
    // fields: clock-select, high enable, low enable, expected enable_n, expected level
    task automatic t_pins;
        logic [4:0] tbl [5] = '{5'b000_10, 5'b100_00, 5'b110_01, 5'b001_00, 5'b111_00};
        logic v;
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 5; i++) begin
            apb(1, SCICT_MODE_ADDR, {24'h0, tbl[i][4], 7'h01}, r, e);
            apb(1, SCICT_SERIAL_CONTROL_ADDR, {30'h0, tbl[i][3:2]}, r, e);
            repeat (3) @(posedge clk_in);
            chk({31'h0, pin.sck_oe_n}, {31'h0, tbl[i][1]});
            if (!tbl[i][2] && !tbl[i][1]) chk({31'h0, pin.sck_out}, {31'h0, tbl[i][0]});
            if (tbl[i][2]) begin
                v = pin.sck_out;
                repeat (DIV) @(posedge clk_in);
                chk({31'h0, pin.sck_out}, {31'h0, ~v});
            end
        end
    endtask
    task automatic t_chr7;
        logic [31:0] r;
        logic e;
        logic [7:0] b;
        apb(1, SCICT_MODE_ADDR, 32'h40, r, e);
        apb(1, SCICT_IRQ_MASK_ADDR, 32'h1, r, e);
        fork
            u_peer.get(b);
            apb(1, SCICT_SERIAL_CONTROL_ADDR, 32'h20, r, e);
        join
        chk({24'h0, b}, 32'hDA);
        repeat (16 * DIV) @(posedge clk_in);
        chk({31'h0, irq}, 32'h0);
        apb(1, SCICT_SERIAL_CONTROL_ADDR, 32'hA0, r, e);
        repeat (3) @(posedge clk_in);
        chk({31'h0, irq}, 32'h1);
        apb(0, SCICT_IRQ_STATUS_ADDR, 0, r, e); chk(r & 32'h1, 32'h1);
        repeat (3) @(posedge clk_in);
        chk({31'h0, irq}, 32'h0);
        apb(1, SCICT_SERIAL_CONTROL_ADDR, 32'h0, r, e);
    endtask
    task automatic t_mp;
        logic [31:0] r;
        logic e;
        apb(1, SCICT_MODE_ADDR, 32'h04, r, e);
        apb(1, SCICT_IRQ_MASK_ADDR, 32'h4, r, e);
        apb(1, SCICT_SERIAL_CONTROL_ADDR, 32'h58, r, e);
        u_peer.send(8'h33, 1'b1, 1'b0);
        chk({31'h0, irq}, 32'h0);
        apb(0, SCICT_SERIAL_CONTROL_ADDR, 0, r, e); chk(r, 32'h58);
        u_peer.send(8'h3C, 1'b1, 1'b1);
        chk({31'h0, irq}, 32'h1);
        apb(0, SCICT_SERIAL_CONTROL_ADDR, 0, r, e); chk(r, 32'h50);
        apb(0, SCICT_RX_DATA_ADDR, 0, r, e); chk(r, 32'h3C);
        apb(0, SCICT_IRQ_STATUS_ADDR, 0, r, e); chk(r & 32'h4, 32'h4);
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == LIMIT) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        t_regs();
        t_pins();
        t_chr7();
        t_mp();
        give_verdict();
    end
endmodule // scict_top_bench
`default_nettype wire
